// ---- hdl/eeprom_pkg.sv ----
package eeprom_pkg;

  // ---------------------------------------------------------------------------
  // Array geometry
  // ---------------------------------------------------------------------------
  localparam int ADDR_W     = 17;
  localparam int BYTE_W     = 8;
  localparam int PAGE_BYTES = 256;
  localparam int FIFO_DEPTH = 8;

  localparam logic [16:0] ADDR_RESET = 17'h00000;

  // ---------------------------------------------------------------------------
  // Device address word layout
  // ---------------------------------------------------------------------------
  localparam logic [3:0] DEV_SELECTOR    = 4'hA;
  localparam int         DEV_SEL_MSB     = 7;
  localparam int         DEV_SEL_LSB     = 4;
  localparam int         DEV_CS_HIGH_BIT = 3;
  localparam int         DEV_CS_LOW_BIT  = 2;
  localparam int         DEV_PAGE_BIT    = 1;
  localparam int         DEV_RW_BIT      = 0;

  // ---------------------------------------------------------------------------
  // Bit counter landmarks within one nine-clock word
  // ---------------------------------------------------------------------------
  localparam logic [3:0] BIT_FIRST = 4'h1;
  localparam logic [3:0] BIT_LAST  = 4'h8;
  localparam logic [3:0] BIT_ACK   = 4'h9;

  // ---------------------------------------------------------------------------
  // Internal program time
  // ---------------------------------------------------------------------------
  localparam int CLK_FREQ_HZ                = 25_000_000;
  localparam int INTERNAL_PROGRAM_TIME_MS   = 5;
  localparam int INTERNAL_PROGRAM_CYCLES    = INTERNAL_PROGRAM_TIME_MS * (CLK_FREQ_HZ / 1000);

  // ---------------------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------------------
  typedef enum logic [2:0] {
    L_IDLE,
    L_DEV,
    L_ADDR_HI,
    L_ADDR_LO,
    L_WDATA,
    L_READ
  } link_state_t;

  typedef enum logic [1:0] {
    P_IDLE,
    P_DRAIN,
    P_RUN
  } prog_state_t;

  typedef struct packed {
    logic [7:0] idx;
    logic [7:0] data;
  } wr_entry_t;

endpackage

// ---- hdl/two_wire_eeprom_target.sv ----
// What this block does
// - SDA changes only while SCL low.
// - SDA fall, SCL high: start new transaction.
// - SDA rise, SCL high: stop, enter standby.
// - Acknowledge each received byte on ninth clock.
// - Standby at reset and after stop, write.
// - Start, nine clocks, start, stop recovers link.
// - Select only when top nibble is 1010.
// - Chip-select bits must match the pins.
// - Seventh bit is top memory address bit.
// - Lowest address bit: one reads, zero writes.
// - Match acknowledges; mismatch returns to standby.
// - Write protect high blocks all array writes.
// - Address: page bit, high byte, low byte.
// - Byte write then stop launches programming.
// - No acknowledge during the program cycle.
// - Page write latches 256 bytes; extra bytes wrap and overwrite.
// - Only low address byte increments, page wraps.
// - Polling: acknowledge once programming has finished.
// - Counter holds last address plus one, wraps.
// - Current read returns byte at the counter.
// - Random read: dummy write, restart, read.
// - Host acknowledge continues read; nack ends it.
// - Sample on SCL rise, drive after fall.
`timescale 1ns/1ns
`default_nettype none

module byte_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  input  wire logic             core_clk_i,
  input  wire logic             rst_n_i,
  input  wire logic [WIDTH-1:0] in_data_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  output logic [WIDTH-1:0]      out_data_o,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i
);

  localparam int PTR_W = $clog2(DEPTH);
  localparam int CNT_W = $clog2(DEPTH + 1);
  localparam logic [CNT_W-1:0] FULL_COUNT = CNT_W'(DEPTH);
  localparam logic [PTR_W-1:0] LAST_PTR   = PTR_W'(DEPTH - 1);

  logic [WIDTH-1:0] store [DEPTH];
  logic [PTR_W-1:0] wr_ptr_reg;
  logic [PTR_W-1:0] rd_ptr_reg;
  logic [CNT_W-1:0] count_reg;
  logic             push;
  logic             pop;

  assign in_ready_o  = (count_reg != FULL_COUNT);
  assign out_valid_o = (count_reg != '0);
  assign out_data_o  = store[rd_ptr_reg];
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;

  always_ff @(posedge core_clk_i) begin
    if (push) begin
      store[wr_ptr_reg] <= in_data_i;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= (wr_ptr_reg == LAST_PTR) ? '0 : wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= (rd_ptr_reg == LAST_PTR) ? '0 : rd_ptr_reg + 1'b1;
      end
      if (push && !pop) begin
        count_reg <= count_reg + 1'b1;
      end else if (pop && !push) begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end

endmodule

module two_wire_eeprom_target #(
  parameter int ADDR_W      = eeprom_pkg::ADDR_W,
  parameter int PROG_CYCLES = eeprom_pkg::INTERNAL_PROGRAM_CYCLES
) (
  input  wire logic core_clk_i,
  input  wire logic rst_n_i,
  input  wire logic scl_i,
  input  wire logic sda_i,
  output logic      sda_o,
  output logic      sda_oe_o,
  input  wire logic chip_select_pin_low_i,
  input  wire logic chip_select_pin_high_i,
  input  wire logic write_protect_i,
  output logic      standby_o,
  output logic      busy_o
);

  localparam int                PAGE_W        = ADDR_W - 8;
  localparam int                PAGE_BYTES    = eeprom_pkg::PAGE_BYTES;
  localparam logic [23:0]       PROG_CNT_LAST = 24'(PROG_CYCLES - 1);
  localparam logic [23:0]       PAGE_CNT_END  = 24'(PAGE_BYTES);

  // ---------------------------------------------------------------------------
  // Pin synchronisers and edge detection
  // ---------------------------------------------------------------------------
  logic [4:0] pin_meta_reg;
  logic [4:0] pin_sync_reg;
  logic       scl_prev_reg;
  logic       sda_prev_reg;
  logic       scl_s;
  logic       sda_s;
  logic       cs_low_s;
  logic       cs_high_s;
  logic       wp_s;
  logic       scl_rise;
  logic       scl_fall;
  logic       start_det;
  logic       stop_det;

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pin_meta_reg <= 5'h03;
      pin_sync_reg <= 5'h03;
      scl_prev_reg <= 1'b1;
      sda_prev_reg <= 1'b1;
    end else begin
      pin_meta_reg <= {write_protect_i, chip_select_pin_high_i, chip_select_pin_low_i, sda_i, scl_i};
      pin_sync_reg <= pin_meta_reg;
      scl_prev_reg <= pin_sync_reg[0];
      sda_prev_reg <= pin_sync_reg[1];
    end
  end

  assign scl_s     = pin_sync_reg[0];
  assign sda_s     = pin_sync_reg[1];
  assign cs_low_s  = pin_sync_reg[2];
  assign cs_high_s = pin_sync_reg[3];
  assign wp_s      = pin_sync_reg[4];
  assign scl_rise  = scl_s && !scl_prev_reg;
  assign scl_fall  = !scl_s && scl_prev_reg;
  // SDA edges while SCL stays high are conditions, never data.
  assign start_det = scl_s && scl_prev_reg && sda_prev_reg && !sda_s;
  assign stop_det  = scl_s && scl_prev_reg && !sda_prev_reg && sda_s;

  // ---------------------------------------------------------------------------
  // Shared state
  // ---------------------------------------------------------------------------
  eeprom_pkg::link_state_t state_reg;
  eeprom_pkg::link_state_t next_state_reg;
  eeprom_pkg::prog_state_t prog_state_reg;

  logic [7:0]        mem [2**ADDR_W];
  logic [7:0]        page_buf [PAGE_BYTES];
  logic [PAGE_BYTES-1:0] page_valid_reg;
  logic [PAGE_W-1:0] page_base_reg;
  logic [23:0]       prog_cnt_reg;

  logic [3:0]        cnt_reg;
  logic [7:0]        shift_reg;
  logic [7:0]        tx_reg;
  logic [7:0]        addr_hi_reg;
  logic [ADDR_W-1:0] addr_reg;
  logic              page_bit_reg;
  logic              in_ack_reg;
  logic              drive_reg;
  logic              host_ack_reg;
  logic              wrote_any_reg;
  logic              sda_out_reg;

  logic [7:0]        rd_byte;
  logic              decide;
  logic              dev_match;
  logic              prog_go;
  logic              page_clear;

  eeprom_pkg::wr_entry_t fifo_in;
  eeprom_pkg::wr_entry_t fifo_out;
  logic                  fifo_in_valid;
  logic                  fifo_in_ready;
  logic                  fifo_out_valid;
  logic                  fifo_out_ready;

  assign rd_byte = mem[addr_reg];
  assign decide  = scl_fall && (cnt_reg == eeprom_pkg::BIT_LAST) && !in_ack_reg
                   && (state_reg != eeprom_pkg::L_IDLE) && (state_reg != eeprom_pkg::L_READ);
  assign dev_match = (shift_reg[eeprom_pkg::DEV_SEL_MSB:eeprom_pkg::DEV_SEL_LSB] == eeprom_pkg::DEV_SELECTOR)
                     && (shift_reg[eeprom_pkg::DEV_CS_HIGH_BIT] == cs_high_s)
                     && (shift_reg[eeprom_pkg::DEV_CS_LOW_BIT] == cs_low_s)
                     && (prog_state_reg == eeprom_pkg::P_IDLE);
  assign page_clear = decide && (state_reg == eeprom_pkg::L_ADDR_LO);
  assign fifo_in_valid = decide && (state_reg == eeprom_pkg::L_WDATA);
  assign fifo_in.idx   = addr_reg[7:0];
  assign fifo_in.data  = shift_reg;
  // A stop after acknowledged data launches programming unless protected.
  assign prog_go = stop_det && (state_reg == eeprom_pkg::L_WDATA) && wrote_any_reg
                   && !wp_s && (prog_state_reg == eeprom_pkg::P_IDLE);

  // ---------------------------------------------------------------------------
  // Serial link engine
  // ---------------------------------------------------------------------------
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_reg      <= eeprom_pkg::L_IDLE;
      next_state_reg <= eeprom_pkg::L_IDLE;
      cnt_reg        <= '0;
      shift_reg      <= '0;
      tx_reg         <= '0;
      addr_hi_reg    <= '0;
      addr_reg       <= eeprom_pkg::ADDR_RESET;
      page_bit_reg   <= 1'b0;
      in_ack_reg     <= 1'b0;
      drive_reg      <= 1'b0;
      host_ack_reg   <= 1'b0;
      wrote_any_reg  <= 1'b0;
    end else if (start_det) begin
      // A start always opens a fresh transaction, which also recovers a hung link.
      state_reg     <= eeprom_pkg::L_DEV;
      cnt_reg       <= '0;
      in_ack_reg    <= 1'b0;
      drive_reg     <= 1'b0;
      wrote_any_reg <= 1'b0;
    end else if (stop_det) begin
      state_reg  <= eeprom_pkg::L_IDLE;
      cnt_reg    <= '0;
      in_ack_reg <= 1'b0;
      drive_reg  <= 1'b0;
    end else if (scl_rise) begin
      if (state_reg == eeprom_pkg::L_READ) begin
        if (cnt_reg == eeprom_pkg::BIT_ACK) begin
          host_ack_reg <= !sda_s;
        end
      end else if (state_reg != eeprom_pkg::L_IDLE && cnt_reg < eeprom_pkg::BIT_LAST) begin
        shift_reg <= {shift_reg[6:0], sda_s};
        cnt_reg   <= cnt_reg + 1'b1;
      end
    end else if (scl_fall) begin
      case (state_reg)
        eeprom_pkg::L_IDLE: begin
          drive_reg <= 1'b0;
        end
        eeprom_pkg::L_READ: begin
          if (cnt_reg < eeprom_pkg::BIT_LAST) begin
            drive_reg <= !tx_reg[6];
            tx_reg    <= {tx_reg[6:0], 1'b0};
            cnt_reg   <= cnt_reg + 1'b1;
          end else if (cnt_reg == eeprom_pkg::BIT_LAST) begin
            drive_reg <= 1'b0;
            cnt_reg   <= eeprom_pkg::BIT_ACK;
          end else if (host_ack_reg) begin
            // Next byte; the counter wraps over the whole array.
            tx_reg    <= rd_byte;
            drive_reg <= !rd_byte[7];
            addr_reg  <= addr_reg + 1'b1;
            cnt_reg   <= eeprom_pkg::BIT_FIRST;
          end else begin
            state_reg <= eeprom_pkg::L_IDLE;
            drive_reg <= 1'b0;
          end
        end
        default: begin
          if (decide) begin
            case (state_reg)
              eeprom_pkg::L_DEV: begin
                if (dev_match) begin
                  in_ack_reg     <= 1'b1;
                  drive_reg      <= 1'b1;
                  page_bit_reg   <= shift_reg[eeprom_pkg::DEV_PAGE_BIT];
                  next_state_reg <= shift_reg[eeprom_pkg::DEV_RW_BIT] ?
                                    eeprom_pkg::L_READ : eeprom_pkg::L_ADDR_HI;
                end else begin
                  state_reg <= eeprom_pkg::L_IDLE;
                end
              end
              eeprom_pkg::L_ADDR_HI: begin
                addr_hi_reg    <= shift_reg;
                in_ack_reg     <= 1'b1;
                drive_reg      <= 1'b1;
                next_state_reg <= eeprom_pkg::L_ADDR_LO;
              end
              eeprom_pkg::L_ADDR_LO: begin
                addr_reg       <= {page_bit_reg, addr_hi_reg, shift_reg};
                in_ack_reg     <= 1'b1;
                drive_reg      <= 1'b1;
                next_state_reg <= eeprom_pkg::L_WDATA;
              end
              eeprom_pkg::L_WDATA: begin
                if (fifo_in_ready) begin
                  // Only the low byte advances, so the write stays in its page.
                  addr_reg[7:0]  <= addr_reg[7:0] + 1'b1;
                  wrote_any_reg  <= 1'b1;
                  in_ack_reg     <= 1'b1;
                  drive_reg      <= 1'b1;
                  next_state_reg <= eeprom_pkg::L_WDATA;
                end else begin
                  state_reg <= eeprom_pkg::L_IDLE;
                end
              end
              default: begin
                state_reg <= eeprom_pkg::L_IDLE;
              end
            endcase
          end else if (in_ack_reg) begin
            in_ack_reg <= 1'b0;
            state_reg  <= next_state_reg;
            if (next_state_reg == eeprom_pkg::L_READ) begin
              tx_reg    <= rd_byte;
              drive_reg <= !rd_byte[7];
              addr_reg  <= addr_reg + 1'b1;
              cnt_reg   <= eeprom_pkg::BIT_FIRST;
            end else begin
              drive_reg <= 1'b0;
              cnt_reg   <= '0;
            end
          end
        end
      endcase
    end
  end

  // ---------------------------------------------------------------------------
  // Received write data buffer
  // ---------------------------------------------------------------------------
  byte_fifo #(
    .WIDTH ($bits(eeprom_pkg::wr_entry_t)),
    .DEPTH (eeprom_pkg::FIFO_DEPTH)
  ) u_wr_fifo (
    .core_clk_i  (core_clk_i),
    .rst_n_i     (rst_n_i),
    .in_data_i   (fifo_in),
    .in_valid_i  (fifo_in_valid),
    .in_ready_o  (fifo_in_ready),
    .out_data_o  (fifo_out),
    .out_valid_o (fifo_out_valid),
    .out_ready_i (fifo_out_ready)
  );

  // The page latch is frozen while it is being committed to the array.
  assign fifo_out_ready = (prog_state_reg != eeprom_pkg::P_RUN);

  // ---------------------------------------------------------------------------
  // Page latch
  // ---------------------------------------------------------------------------
  always_ff @(posedge core_clk_i) begin
    if (fifo_out_valid && fifo_out_ready) begin
      page_buf[fifo_out.idx] <= fifo_out.data;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      page_valid_reg <= '0;
      page_base_reg  <= '0;
    end else if (page_clear) begin
      page_valid_reg <= '0;
      page_base_reg  <= {page_bit_reg, addr_hi_reg};
    end else if (fifo_out_valid && fifo_out_ready) begin
      page_valid_reg[fifo_out.idx] <= 1'b1;
    end
  end

  // ---------------------------------------------------------------------------
  // Self-timed program cycle
  // ---------------------------------------------------------------------------
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      prog_state_reg <= eeprom_pkg::P_IDLE;
      prog_cnt_reg   <= '0;
    end else begin
      case (prog_state_reg)
        eeprom_pkg::P_IDLE: begin
          if (prog_go) begin
            prog_state_reg <= eeprom_pkg::P_DRAIN;
          end
        end
        eeprom_pkg::P_DRAIN: begin
          if (!fifo_out_valid) begin
            prog_state_reg <= eeprom_pkg::P_RUN;
            prog_cnt_reg   <= '0;
          end
        end
        eeprom_pkg::P_RUN: begin
          if (prog_cnt_reg == PROG_CNT_LAST) begin
            prog_state_reg <= eeprom_pkg::P_IDLE;
          end else begin
            prog_cnt_reg <= prog_cnt_reg + 1'b1;
          end
        end
        default: begin
          prog_state_reg <= eeprom_pkg::P_IDLE;
        end
      endcase
    end
  end

  // Commits one latched byte per cycle during the first part of the program time.
  always_ff @(posedge core_clk_i) begin
    if (prog_state_reg == eeprom_pkg::P_RUN && prog_cnt_reg < PAGE_CNT_END
        && page_valid_reg[prog_cnt_reg[7:0]]) begin
      mem[{page_base_reg, prog_cnt_reg[7:0]}] <= page_buf[prog_cnt_reg[7:0]];
    end
  end

  // ---------------------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------------------
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sda_out_reg <= 1'b0;
    end else begin
      sda_out_reg <= 1'b0;
    end
  end

  assign sda_o     = sda_out_reg;
  assign sda_oe_o  = drive_reg;
  assign busy_o    = (prog_state_reg != eeprom_pkg::P_IDLE);
  assign standby_o = (state_reg == eeprom_pkg::L_IDLE) && !busy_o;

endmodule

`default_nettype wire

// ---- sim/two_wire_eeprom_target_props.sv ----
`timescale 1ns/1ns
`default_nettype none
module eeprom_props #(
  parameter int ADDR_W      = 17,
  parameter int PROG_CYCLES = 300
) (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic sda_o,
  input wire logic sda_oe_o,
  input wire logic chip_select_pin_low_i,
  input wire logic chip_select_pin_high_i,
  input wire logic write_protect_i,
  input wire logic standby_o,
  input wire logic busy_o
);
  logic [31:0] busy_cnt;

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i)
      busy_cnt <= 32'h0;
    else
      busy_cnt <= busy_o ? busy_cnt + 32'h1 : 32'h0;
  end

  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!rst_n_i);

  AST_OPEN_DRAIN: assert property (sda_o == 1'b0)
    else $error("sda value not zero");
  AST_DRIVE_AFTER_FALL: assert property ($changed(sda_oe_o) |-> !scl_i && !$past(scl_i, 2))
    else $error("sda drive moved near clock high");
  AST_START_WAKES: assert property (scl_i && $past(scl_i) && $fell(sda_i) |->
      ##[1:8] (!standby_o || busy_o))
    else $error("start left device idle");
  AST_STOP_SLEEPS: assert property (scl_i && $past(scl_i) && $rose(sda_i) |->
      ##[1:8] (standby_o || busy_o))
    else $error("stop did not end transfer");
  AST_RESET_IDLE: assert property ($rose(rst_n_i) |-> standby_o && !busy_o && !sda_oe_o)
    else $error("not idle after reset");
  AST_BUSY_NOT_IDLE: assert property (!(busy_o && standby_o))
    else $error("standby during program cycle");
  AST_IDLE_SILENT: assert property (standby_o |-> !sda_oe_o)
    else $error("sda driven in standby");
  AST_BUSY_SILENT: assert property (busy_o |-> !sda_oe_o)
    else $error("sda driven while programming");
  AST_PROG_LENGTH: assert property ($fell(busy_o) |->
      busy_cnt >= PROG_CYCLES && busy_cnt <= PROG_CYCLES + 600)
    else $error("program cycle length wrong");
  AST_PROTECT: assert property ($rose(busy_o) |-> !$past(write_protect_i, 4))
    else $error("programming under write protect");
endmodule

bind two_wire_eeprom_target eeprom_props #(.ADDR_W(ADDR_W), .PROG_CYCLES(PROG_CYCLES)) u_props (
  .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o),
  .sda_oe_o(sda_oe_o), .chip_select_pin_low_i(chip_select_pin_low_i),
  .chip_select_pin_high_i(chip_select_pin_high_i), .write_protect_i(write_protect_i),
  .standby_o(standby_o), .busy_o(busy_o)
);
`default_nettype wire

// ---- sim/host_ctrl_model.sv ----
`timescale 1ns/1ns
`default_nettype none
module host_ctrl_model (
  output logic      scl_o,
  output logic      sda_low_o,
  input  wire logic sda_i
);
  int tq   = 80;
  int slow = 0;

  initial begin
    scl_o = 1'b1;
    sda_low_o = 1'b0;
  end

  // SDA moves only with SCL low; a larger slow stretches the low phase.
  task automatic bit_out(input logic b, output logic s);
    sda_low_o = !b;
    #(tq * (1 + slow));
    scl_o = 1'b1;
    #tq;
    s = sda_i;
    #tq;
    scl_o = 1'b0;
    #tq;
  endtask

  task automatic start();
    sda_low_o = 1'b0;
    #tq;
    scl_o = 1'b1;
    #tq;
    sda_low_o = 1'b1;
    #tq;
    scl_o = 1'b0;
    #tq;
  endtask

  task automatic stop();
    sda_low_o = 1'b1;
    #tq;
    scl_o = 1'b1;
    #tq;
    sda_low_o = 1'b0;
    #(2 * tq);
  endtask

  task automatic put(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--)
      bit_out(b[i], s);
    bit_out(1'b1, s);
    ack = !s;
  endtask

  task automatic get(input logic last, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_out(1'b1, s);
      b[i] = s;
    end
    bit_out(last, s);
  endtask

  task automatic recover();
    logic s;
    start();
    repeat (9) bit_out(1'b1, s);
    start();
    stop();
  endtask
endmodule
`default_nettype wire

// ---- sim/two_wire_eeprom_target_bench.sv ----
`timescale 1ns/1ns
`default_nettype none
module two_wire_eeprom_target_bench;
  logic        core_clk    = 1'b0;
  logic        rst_n       = 1'b0;
  logic        cs_lo       = 1'b0;
  logic        cs_hi       = 1'b0;
  logic        wp          = 1'b0;
  logic        scl;
  logic        host_low;
  logic        sda_val;
  logic        sda_oe;
  logic        standby;
  logic        busy;
  logic [16:0] cnt_exp     = 17'h00000;
  logic [7:0]  mem[logic [16:0]];
  int          miscompares = 0;
  int          checks_done = 0;
  wire logic   sda_w       = !(host_low || sda_oe);

  host_ctrl_model u_host (.scl_o(scl), .sda_low_o(host_low), .sda_i(sda_w));

  two_wire_eeprom_target #(.PROG_CYCLES(300)) u_dut (
    .core_clk_i(core_clk), .rst_n_i(rst_n), .scl_i(scl), .sda_i(sda_w), .sda_o(sda_val),
    .sda_oe_o(sda_oe), .chip_select_pin_low_i(cs_lo), .chip_select_pin_high_i(cs_hi),
    .write_protect_i(wp), .standby_o(standby), .busy_o(busy)
  );

  always #20 core_clk = ~core_clk;

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic test_done();
    $display("checks=%0d mismatches=%0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  function automatic logic [7:0] dw(input logic [3:0] s, input logic [1:0] cs, input logic pg, input logic rd);
    return {s, cs, pg, rd};
  endfunction

  task automatic set_in(input logic [2:0] v);
    @(posedge core_clk);
    #1;
    {wp, cs_hi, cs_lo} = v;
  endtask

  task automatic sel(input logic pg, input logic rd, output logic ack);
    u_host.start();
    u_host.put(dw(4'hA, {cs_hi, cs_lo}, pg, rd), ack);
  endtask

  task automatic hdr(input logic [16:0] a);
    logic ack;
    sel(a[16], 1'b0, ack);
    chk(32'(ack), 32'h1);
    u_host.put(a[15:8], ack);
    chk(32'(ack), 32'h1);
    u_host.put(a[7:0], ack);
    chk(32'(ack), 32'h1);
    cnt_exp = a;
  endtask

  task automatic wr(input logic [16:0] a, input int n);
    logic       ack;
    logic [7:0] d;
    int         k;
    hdr(a);
    for (int i = 0; i < n; i++) begin
      d = 8'($urandom);
      u_host.put(d, ack);
      chk(32'(ack), 32'h1);
      if (!wp)
        mem[{a[16:8], a[7:0] + 8'(i)}] = d;
    end
    u_host.stop();
    cnt_exp = {a[16:8], a[7:0] + 8'(n)};
    repeat (8) @(posedge core_clk);
    #1;
    chk(32'(busy), 32'(n > 0 && !wp));
    k = 0;
    do begin
      sel(1'b0, 1'b0, ack);
      u_host.stop();
      k++;
    end while (!ack && k < 50);
    chk(32'(k > 1), 32'(n > 0 && !wp));
    chk(32'({ack, busy, standby}), 32'h5);
  endtask

  task automatic rd(input logic rnd, input logic [16:0] a, input int n);
    logic       ack;
    logic [7:0] d;
    if (rnd)
      hdr(a);
    sel(cnt_exp[16], 1'b1, ack);
    chk(32'(ack), 32'h1);
    for (int i = 0; i < n; i++) begin
      u_host.get(i == n - 1, d);
      chk(32'(d), 32'(mem[cnt_exp]));
      cnt_exp = cnt_exp + 17'h1;
    end
    u_host.stop();
  endtask

  initial begin
    logic [16:0] a;
    logic        ack;
    bit          m;
    void'($urandom(23));
    repeat (10) @(posedge core_clk);
    #1;
    rst_n = 1'b1;
    repeat (4) @(posedge core_clk);
    #1;
    chk(32'({standby, busy, sda_oe}), 32'h4);
    for (int k = 0; k < 16; k++) begin
      if (k % 8 == 0)
        set_in(3'($urandom % 4));
      m = !k[2] && k[1:0] == {cs_hi, cs_lo};
      u_host.start();
      u_host.put(dw(k[2] ? 4'($urandom % 10) : 4'hA, k[1:0], k[3], 1'b0), ack);
      repeat (4) @(posedge core_clk);
      #1;
      chk(32'(ack), 32'(m));
      chk(32'(standby), 32'(!m));
      u_host.stop();
    end
    $display("test select done");
    a = {1'($urandom), 8'($urandom), 8'hFD};
    wr(a, 5);
    rd(1'b1, a, 3);
    rd(1'b1, {a[16:8], 8'h00}, 1);
    rd(1'b0, 17'h00000, 1);
    $display("test page wrap done");
    u_host.slow = 2;
    wr(a ^ 17'h10000, 258);
    rd(1'b1, a ^ 17'h10000, 3);
    u_host.slow = 0;
    $display("test long page done");
    set_in({1'b1, cs_hi, cs_lo});
    wr(a, 2);
    set_in({1'b0, cs_hi, cs_lo});
    rd(1'b1, a, 2);
    $display("test protect done");
    wr(17'h1FFFF, 1);
    wr(17'h00000, 1);
    rd(1'b1, 17'h1FFFF, 2);
    $display("test array wrap done");
    sel(1'b0, 1'b0, ack);
    u_host.put(8'h00, ack);
    u_host.recover();
    repeat (8) @(posedge core_clk);
    #1;
    chk(32'(standby), 32'h1);
    rd(1'b1, 17'h1FFFF, 1);
    $display("test recover done");
    test_done();
  end

  initial begin
    #4_000_000;
    miscompares++;
    test_done();
  end
endmodule
`default_nettype wire
